// [common/psrpm_pkg.sv]
// Package: constants, register map and types of the sleep-mode controller
package psrpm_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 40;
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SLP_WE_MAX_US  = 1;     // sleep_to_write_max
    localparam int DS_MIN_US      = 10;    // deep_sleep_min_time
    localparam int RECOV_US       = 200;   // deep_sleep_recovery_time
    localparam int WP_MIN_NS      = 50;    // write pulse width
    localparam int SLP_WE_CYC     = SLP_WE_MAX_US * CLK_MHZ;
    localparam int DS_MIN_CYC     = DS_MIN_US * CLK_MHZ;
    localparam int RECOV_CYC_DFLT = RECOV_US * CLK_MHZ;
    localparam int WP_CYC         = (WP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W          = 14;

    // ------------------------------------------------------------------
    // Device configuration register fields
    // ------------------------------------------------------------------
    localparam int CFG_W          = 21;
    localparam int CFG_SIZE_LSB   = 0;
    localparam int CFG_TOP_BIT    = 2;
    localparam int CFG_MODE_BIT   = 3;
    localparam int CFG_DSDIS_BIT  = 4;
    localparam logic [CFG_W-1:0] CFG_DFLT     = 21'h000010;
    localparam logic [CFG_W-1:0] CFG_USED_MSK = 21'h00001F;
    localparam logic [1:0] SIZE_QUARTER = 2'h3;
    localparam logic [1:0] SIZE_HALF    = 2'h2;

    // ------------------------------------------------------------------
    // Controller registers on the bus
    // ------------------------------------------------------------------
    localparam logic [1:0] REG_CTRL = 2'h0;   // byte 0x0
    localparam logic [1:0] REG_CFG  = 2'h1;   // byte 0x4
    localparam logic [1:0] REG_STAT = 2'h2;   // byte 0x8
    localparam int CTRL_LOAD_BIT  = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    localparam int CTRL_WAKE_BIT  = 2;
    localparam int STAT_REF_BIT   = 8;
    localparam int STAT_RDY_BIT   = 9;
    localparam int STAT_MIN_BIT   = 10;
    localparam int STAT_MIR_LSB   = 11;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ZZ_SETUP = 7'h02,
        ST_WE_LOW   = 7'h04,
        ST_WE_REL   = 7'h08,
        ST_SLEEP    = 7'h10,
        ST_DEEP     = 7'h20,
        ST_RECOVER  = 7'h40
    } psrpm_state_t;

    typedef struct packed {
        logic             sleep_ctrl_n;
        logic             ce_n;
        logic             we_n;
        logic [CFG_W-1:0] addr;
    } psrpm_pins_t;

    localparam psrpm_pins_t PINS_RST = '{sleep_ctrl_n: 1'b1, ce_n: 1'b1, we_n: 1'b1,
                                         addr: 21'h000000};

endpackage

// [src/psrpm_timer.sv]
// Down counter used for the pulse, minimum sleep and recovery intervals
module psrpm_timer
    import psrpm_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_load,
    input  wire logic [TMR_W-1:0] i_count,
    output logic                  o_done
);

    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (i_load) begin
            cnt_nxt = i_count;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_done = (cnt_r == '0);

endmodule

// [src/psrpm_ctrl.sv]
// Host-side power mode controller for the pseudo-static RAM, with a Wishbone slave
module psrpm_ctrl
    import psrpm_pkg::*;
#(
    parameter int unsigned RECOV_CYC = RECOV_CYC_DFLT
)
(
    input  wire logic                   I_CLK_SYS,
    input  wire logic                   I_RESET,
    input  wire logic                   I_WB_CYC,
    input  wire logic                   I_WB_STB,
    input  wire logic                   I_WB_WE,
    input  wire logic [31:0]            I_WB_ADR,
    input  wire logic [3:0]             I_WB_SEL,
    input  wire logic [31:0]            I_WB_DAT,
    output logic      [31:0]            O_WB_DAT,
    output logic                        O_WB_ACK,
    output psrpm_pkg::psrpm_pins_t      O_PINS,
    output logic                        O_MEM_READY,
    input  wire logic [20:0]            I_ACC_ADDR,
    output logic                        O_ADDR_OK
);
    import psrpm_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    psrpm_state_t     state_r,    state_nxt;
    psrpm_pins_t      pins_r,     pins_nxt;
    logic [CFG_W-1:0] cfg_r,      cfg_nxt;
    logic [CFG_W-1:0] load_val_r, load_val_nxt;
    logic [CFG_W-1:0] mirror_r,   mirror_nxt;
    logic             refused_r,  refused_nxt;
    logic             ack_r,      ack_nxt;
    logic [31:0]      rdat_r,     rdat_nxt;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_cnt;
    logic             tmr_done;
    logic             req;
    logic             wr;
    logic [1:0]       reg_idx;
    logic             cmd_load;
    logic             cmd_sleep;
    logic             cmd_wake;
    logic             cmd_ok;

    psrpm_timer u_timer (
        .i_clk   (I_CLK_SYS),
        .i_reset (I_RESET),
        .i_load  (tmr_load),
        .i_count (tmr_cnt),
        .o_done  (tmr_done)
    );

    // ------------------------------------------------------------------
    // Active section check
    // ------------------------------------------------------------------
    function automatic logic in_section(input logic [20:0] a, input logic [CFG_W-1:0] c);
        logic top;
        logic ok;
        top = c[CFG_TOP_BIT];
        ok  = 1'b1;
        case (c[CFG_SIZE_LSB +: 2])
            SIZE_QUARTER: ok = (a[20:19] == {top, top});
            SIZE_HALF:    ok = (a[20] == top);
            default:      ok = 1'b1;
        endcase
        return ok;
    endfunction

    // Only reduced size mode makes the unselected part unusable
    assign O_ADDR_OK   = !mirror_r[CFG_MODE_BIT] || in_section(I_ACC_ADDR, mirror_r);
    assign O_MEM_READY = (state_r == ST_IDLE);
    assign O_PINS      = pins_r;
    assign O_WB_ACK    = ack_r;
    assign O_WB_DAT    = rdat_r;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign req       = I_WB_CYC && I_WB_STB && !ack_r;
    assign wr        = req && I_WB_WE;
    assign reg_idx   = I_WB_ADR[3:2];
    assign cmd_load  = wr && (reg_idx == REG_CTRL) && I_WB_SEL[0] && I_WB_DAT[CTRL_LOAD_BIT];
    assign cmd_sleep = wr && (reg_idx == REG_CTRL) && I_WB_SEL[0] && I_WB_DAT[CTRL_SLEEP_BIT];
    assign cmd_wake  = wr && (reg_idx == REG_CTRL) && I_WB_SEL[0] && I_WB_DAT[CTRL_WAKE_BIT];

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        pins_nxt     = pins_r;
        cfg_nxt      = cfg_r;
        load_val_nxt = load_val_r;
        mirror_nxt   = mirror_r;
        refused_nxt  = refused_r;
        tmr_load     = 1'b0;
        tmr_cnt      = '0;
        cmd_ok       = 1'b0;
        ack_nxt      = req;
        rdat_nxt     = '0;

        if (wr && (reg_idx == REG_CFG)) begin
            for (int b = 0; b < 2; b++) begin
                if (I_WB_SEL[b]) begin
                    cfg_nxt[b*8 +: 8] = I_WB_DAT[b*8 +: 8];
                end
            end
            // Top lane carries only the five register bits above bit 15
            if (I_WB_SEL[2]) begin
                cfg_nxt[CFG_W-1:16] = I_WB_DAT[CFG_W-1:16];
            end
        end

        if (req && !I_WB_WE) begin
            case (reg_idx)
                REG_CFG: rdat_nxt = {11'h000, cfg_r};
                REG_STAT: begin
                    rdat_nxt[6:0]                   = state_r;
                    rdat_nxt[STAT_REF_BIT]          = refused_r;
                    rdat_nxt[STAT_RDY_BIT]          = (state_r == ST_IDLE);
                    rdat_nxt[STAT_MIN_BIT]          = (state_r == ST_DEEP) && tmr_done;
                    rdat_nxt[STAT_MIR_LSB +: CFG_W] = mirror_r;
                end
                default: rdat_nxt = '0;
            endcase
        end

        case (state_r)
            ST_IDLE: begin
                if (cmd_load) begin
                    cmd_ok                = 1'b1;
                    load_val_nxt          = cfg_r & CFG_USED_MSK;
                    pins_nxt.addr         = cfg_r & CFG_USED_MSK;
                    pins_nxt.sleep_ctrl_n = 1'b0;
                    state_nxt             = ST_ZZ_SETUP;
                end else if (cmd_sleep) begin
                    cmd_ok                = 1'b1;
                    pins_nxt.sleep_ctrl_n = 1'b0;
                    if (!mirror_r[CFG_DSDIS_BIT]) begin
                        tmr_load  = 1'b1;
                        tmr_cnt   = TMR_W'(DS_MIN_CYC);
                        state_nxt = ST_DEEP;
                    end else begin
                        state_nxt = ST_SLEEP;
                    end
                end
            end
            ST_ZZ_SETUP: begin
                // One cycle after the pin falls, well inside the limit
                pins_nxt.ce_n = 1'b0;
                pins_nxt.we_n = 1'b0;
                tmr_load      = 1'b1;
                tmr_cnt       = TMR_W'(WP_CYC - 1);
                state_nxt     = ST_WE_LOW;
            end
            ST_WE_LOW: begin
                if (tmr_done) begin
                    pins_nxt.ce_n = 1'b1;
                    pins_nxt.we_n = 1'b1;
                    state_nxt     = ST_WE_REL;
                end
            end
            ST_WE_REL: begin
                // The new setting takes hold as the pin rises
                pins_nxt.sleep_ctrl_n = 1'b1;
                mirror_nxt            = load_val_r;
                state_nxt             = ST_IDLE;
            end
            ST_SLEEP: begin
                if (cmd_wake) begin
                    cmd_ok                = 1'b1;
                    pins_nxt.sleep_ctrl_n = 1'b1;
                    state_nxt             = ST_IDLE;
                end
            end
            ST_DEEP: begin
                // An early wake is refused rather than deferred
                if (cmd_wake && tmr_done) begin
                    cmd_ok                = 1'b1;
                    pins_nxt.sleep_ctrl_n = 1'b1;
                    mirror_nxt            = CFG_DFLT;
                    tmr_load              = 1'b1;
                    tmr_cnt               = TMR_W'(RECOV_CYC);
                    state_nxt             = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                pins_nxt  = PINS_RST;
                state_nxt = ST_IDLE;
            end
        endcase

        if (cmd_ok) begin
            refused_nxt = 1'b0;
        end else if (cmd_load || cmd_sleep || cmd_wake) begin
            refused_nxt = 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            state_r    <= ST_IDLE;
            pins_r     <= PINS_RST;
            cfg_r      <= CFG_DFLT;
            load_val_r <= CFG_DFLT;
            mirror_r   <= CFG_DFLT;
            refused_r  <= 1'b0;
            ack_r      <= 1'b0;
            rdat_r     <= '0;
        end else begin
            state_r    <= state_nxt;
            pins_r     <= pins_nxt;
            cfg_r      <= cfg_nxt;
            load_val_r <= load_val_nxt;
            mirror_r   <= mirror_nxt;
            refused_r  <= refused_nxt;
            ack_r      <= ack_nxt;
            rdat_r     <= rdat_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    logic [15:0] low_cnt_r,  low_cnt_nxt;
    logic [15:0] wake_cnt_r, wake_cnt_nxt;

    always_comb begin
        low_cnt_nxt  = low_cnt_r;
        wake_cnt_nxt = wake_cnt_r;
        if (pins_r.sleep_ctrl_n) begin
            low_cnt_nxt = '0;
        end else if (low_cnt_r != 16'hFFFF) begin
            low_cnt_nxt = low_cnt_r + 1'b1;
        end
        if (state_r == ST_DEEP) begin
            wake_cnt_nxt = '0;
        end else if (wake_cnt_r != 16'hFFFF) begin
            wake_cnt_nxt = wake_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            low_cnt_r  <= '0;
            wake_cnt_r <= 16'hFFFF;
        end else begin
            low_cnt_r  <= low_cnt_nxt;
            wake_cnt_r <= wake_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_zz_to_we: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        $fell(pins_r.sleep_ctrl_n) && (state_r == ST_ZZ_SETUP) |-> ##[1:40] !pins_r.we_n)
        else $error("write enable late after sleep pin fall");

    a_load_write: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        !pins_r.we_n |-> !pins_r.sleep_ctrl_n && !pins_r.ce_n && (pins_r.addr == load_val_r))
        else $error("write without sleep pin low or wrong value");

    a_we_pulse: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        $fell(pins_r.we_n) |-> !pins_r.we_n [*2] ##1 pins_r.we_n ##1 pins_r.sleep_ctrl_n)
        else $error("write pulse shape wrong");

    a_reload_take: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (state_r == ST_WE_REL) |=> (mirror_r == $past(load_val_r)) && pins_r.sleep_ctrl_n)
        else $error("loaded value not in force after pin rise");

    a_addr_window: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        mirror_r[CFG_MODE_BIT] && (mirror_r[1:0] == SIZE_QUARTER) &&
        (I_ACC_ADDR[20:19] != {2{mirror_r[CFG_TOP_BIT]}}) |-> !O_ADDR_OK)
        else $error("access outside active section allowed");

    a_reserved_zero: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        !pins_r.we_n |-> (pins_r.addr[20:5] == 16'h0000))
        else $error("reserved bits not zero during load");

    a_deep_min: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        $rose(pins_r.sleep_ctrl_n) && (state_r == ST_RECOVER) |->
        ($past(low_cnt_r) >= 16'(DS_MIN_CYC)))
        else $error("deep sleep held too short");

    a_recover_wait: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        $rose(O_MEM_READY) && ($past(state_r) == ST_RECOVER) |-> (wake_cnt_r >= 16'(RECOV_CYC)))
        else $error("memory ready before recovery time");

    a_deep_default: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (state_r == ST_RECOVER) |-> (mirror_r == CFG_DFLT))
        else $error("defaults not restored after deep sleep");

    a_wb_ack: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("bus ack not one cycle after request");

endmodule

// [verification/psrpm_mem_model.sv]
// Behavioural model of the memory's power mode logic, driven by the controller pins
module psrpm_mem_model
#(
    parameter real REC_NS = 500.0
)
(
    input  wire psrpm_pkg::psrpm_pins_t i_pins,
    output logic [20:0]                 o_cfg,
    output logic                        o_deep,
    output logic                        o_part_ref,
    output logic                        o_lost,
    output logic [7:0]                  o_viol
);
    import psrpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    real         t_zz    = 0.0;
    real         t_wake  = -1.0e9;
    logic        loaded  = 1'b0;
    logic        standby = 1'b0;
    logic [20:0] new_cfg = 21'h000000;

    initial begin
        o_cfg  = CFG_DFLT;
        o_deep = 1'b0;
        o_lost = 1'b0;
        o_viol = 8'h00;
    end

    // --------------------------------------------------------------
    // Sleep pin falls: standby, or deep sleep when enabled
    // --------------------------------------------------------------
    always @(negedge i_pins.sleep_ctrl_n) begin
        t_zz    = $realtime;
        loaded  = 1'b0;
        o_deep  = ~o_cfg[CFG_DSDIS_BIT];
        standby = o_cfg[CFG_DSDIS_BIT];
    end

    // A write while the pin is low is a register load, not a sleep
    always @(negedge i_pins.we_n) begin
        if (!i_pins.sleep_ctrl_n && !i_pins.ce_n) begin
            if ($realtime - t_zz > 1000.0) o_viol++;
            new_cfg = i_pins.addr;
            loaded  = 1'b1;
            o_deep  = 1'b0;
            standby = 1'b0;
            if (new_cfg[20:5] != 16'h0000) o_viol++;
        end
    end

    // --------------------------------------------------------------
    // Sleep pin rises: new settings take effect, deep sleep ends
    // --------------------------------------------------------------
    always @(posedge i_pins.sleep_ctrl_n) begin
        if (o_deep === 1'b1) begin
            if ($realtime - t_zz < 10000.0) o_viol++;
            o_cfg  = CFG_DFLT;
            o_lost = 1'b1;
            t_wake = $realtime;
        end else if (loaded) begin
            // Fields kept whole; section ends follow A2..A0
            o_cfg = new_cfg;
        end
        o_deep  = 1'b0;
        standby = 1'b0;
        loaded  = 1'b0;
    end

    // A chip select with the sleep pin high too soon after deep sleep is a fault of the controller
    always @(negedge i_pins.ce_n) begin
        if (i_pins.sleep_ctrl_n && ($realtime - t_wake < REC_NS)) o_viol++;
    end

    // Only the chosen section is refreshed while in partial standby
    assign o_part_ref = standby & ~o_cfg[CFG_MODE_BIT] & o_cfg[CFG_SIZE_LSB+1];
endmodule

// [verification/psram_power_mode_control_tb_top.sv]
// Self-checking testbench of the power mode controller with a memory model
module psram_power_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psrpm_pkg::*;

    localparam int unsigned RCYC = 20;   // Short recovery keeps the run brief

    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic [31:0] adr  = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel  = 4'h0;
    logic [20:0] acc  = 21'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        ready;
    logic        aok;
    psrpm_pins_t pins;
    logic [20:0] m_cfg;
    logic        m_deep;
    logic        m_pref;
    logic        m_lost;
    logic [7:0]  m_viol;
    logic [31:0] rd;
    int          n;
    int          err_count = 0;
    int          cmp_count = 0;
    logic [20:0] cfgs [9]  = '{21'h1B, 21'h1A, 21'h1F, 21'h1E, 21'h13, 21'h12, 21'h17,
                              21'h16, 21'h10};
    logic [20:0] probe [8] = '{21'h000000, 21'h07FFFF, 21'h080000, 21'h0FFFFF,
                              21'h100000, 21'h17FFFF, 21'h180000, 21'h1FFFFF};

    always #12.5 clk = ~clk;

    psrpm_ctrl #(.RECOV_CYC(RCYC)) psrpm_ctrl_inst (
        .I_CLK_SYS(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .O_PINS(pins), .O_MEM_READY(ready), .I_ACC_ADDR(acc), .O_ADDR_OK(aok)
    );

    psrpm_mem_model #(.REC_NS(RCYC * 25.0)) psrpm_mem_model_inst (
        .i_pins(pins), .o_cfg(m_cfg), .o_deep(m_deep), .o_part_ref(m_pref),
        .o_lost(m_lost), .o_viol(m_viol)
    );

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // Registered slave: ack is seen at the second edge after the request rises
        chk("wb_latency", k, 32'h2);
    endtask

    task automatic wait_ready();
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) chk("ready_wait", 32'h0, 32'h1);
    endtask

    // Reserved bits set on purpose: the controller must clear them on the pins
    task automatic load(input logic [20:0] v);
        wb(1'b1, 32'h4, {11'h0, v | 21'h1FFFE0});
        wb(1'b1, 32'h0, 32'h1);
        wait_ready();
    endtask

    function automatic logic ok_exp(input logic [20:0] c, input logic [20:0] a);
        if (!c[3]) return 1'b1;
        case (c[1:0])
            2'b11:   return c[2] ? (a >= 21'h180000) : (a <= 21'h07FFFF);
            2'b10:   return c[2] ? (a >= 21'h100000) : (a <= 21'h0FFFFF);
            default: return 1'b1;
        endcase
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, 32'h4, 32'h0);
        chk("cfg_reset", rd, 32'h10);
        wb(1'b0, 32'h8, 32'h0);
        chk("stat_reset", rd, (32'h10 << 11) | 32'h201);
        wb(1'b1, 32'hC, 32'hFFFFFFFF);
        wb(1'b0, 32'hC, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("pins_reset", {8'h0, pins}, {8'h0, PINS_RST});
        $display("test reset done");

        foreach (cfgs[i]) begin
            load(cfgs[i]);
            chk("dev_cfg", m_cfg, cfgs[i]);
            wb(1'b0, 32'h8, 32'h0);
            chk("mirror", rd[31:11], cfgs[i]);
            foreach (probe[j]) begin
                @(posedge clk);
                acc <= probe[j];
                #1;
                chk("addr_ok", aok, ok_exp(cfgs[i], probe[j]));
            end
        end
        $display("test modes done");

        wb(1'b1, 32'h4, 32'h1B);
        wb(1'b1, 32'h0, 32'h1);
        @(posedge clk);
        #1;
        chk("zz_low", pins.sleep_ctrl_n, 1'b0);
        chk("busy", ready, 1'b0);
        wb(1'b1, 32'h0, 32'h1);
        wb(1'b0, 32'h8, 32'h0);
        chk("refused", rd[8], 1'b1);
        wait_ready();
        chk("dev_cfg2", m_cfg, 21'h1B);
        $display("test load walk done");

        load(21'h13);
        wb(1'b1, 32'h0, 32'h2);
        wb(1'b0, 32'h8, 32'h0);
        chk("standby", rd[6:0], 7'h10);
        chk("part_ref", m_pref, 1'b1);
        chk("no_deep", m_deep, 1'b0);
        wb(1'b1, 32'h0, 32'h4);
        wait_ready();
        chk("full_ref", m_pref, 1'b0);
        wb(1'b1, 32'h0, 32'h2);
        wb(1'b0, 32'h8, 32'h0);
        chk("part_ref2", m_pref, 1'b1);
        wb(1'b1, 32'h0, 32'h4);
        wait_ready();
        $display("test standby done");

        load(21'h00);
        wb(1'b1, 32'h0, 32'h2);
        wb(1'b0, 32'h8, 32'h0);
        chk("deep_state", rd[6:0], 7'h20);
        chk("deep_dev", m_deep, 1'b1);
        wb(1'b1, 32'h0, 32'h4);
        wb(1'b0, 32'h8, 32'h0);
        chk("early_wake", {rd[10:8], 1'b0, rd[6:0]}, {3'b001, 1'b0, 7'h20});
        repeat (400) @(posedge clk);
        wb(1'b0, 32'h8, 32'h0);
        chk("min_done", rd[10], 1'b1);
        wb(1'b1, 32'h0, 32'h4);
        wait_ready();
        chk("recover_len", n >= RCYC, 1'b1);
        chk("dev_dflt", m_cfg, 21'h10);
        chk("data_lost", m_lost, 1'b1);
        wb(1'b0, 32'h8, 32'h0);
        chk("mirror_dflt", rd[31:11], 21'h10);
        chk("pin_faults", m_viol, 8'h00);
        $display("test deep sleep done");
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
